// *** hw/dio_regs_pkg.sv ***
// constants and carrier types for the port-two mode and power-output register block
package dio_regs_pkg;
  localparam logic [3:0] OFS_GROUP_A = 4'h4;
  localparam logic [3:0] OFS_GROUP_B = 4'h5;
  localparam logic [3:0] OFS_GROUP_C = 4'h6;
  localparam logic [3:0] OFS_MODE_CTRL = 4'h7;
  localparam logic [3:0] OFS_POWER_0 = 4'h8;
  localparam logic [3:0] OFS_POWER_1 = 4'h9;
  localparam logic [3:0] OFS_POWER_2 = 4'ha;
  localparam logic [3:0] OFS_POWER_3 = 4'hb;
  localparam logic [1:0] MODE_UNDEF = 2'h0;
  localparam logic [1:0] MODE_PRESET = 2'h1;
  localparam logic [1:0] MODE_DIRECTION = 2'h2;
  localparam logic [1:0] MODE_OPERATION = 2'h3;
  localparam logic [1:0] MODE_RESET = 2'h3;
  localparam logic [7:0] GROUP_RESET = 8'h00;
  localparam logic [3:0] POWER_RESET = 4'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam int IN_LSB = 4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } bus_req_type;

  typedef struct packed {
    logic [7:0] value;
    logic [7:0] dir;
  } group_state_type;

  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] power;
    logic [7:0] rdata;
  } top_state_type;
endpackage

// *** hw/port2_group.sv ***
// one 8-bit port-two data group: value and direction storage under the mode field
`timescale 1ns/1ns
module port2_group #(
  parameter int WIDTH = 8
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic [1:0] i_mode,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [WIDTH-1:0] i_pins,
  output logic [WIDTH-1:0] o_pin_out,
  output logic [WIDTH-1:0] o_pin_oe,
  output logic [WIDTH-1:0] o_rdata
);
  dio_regs_pkg::group_state_type st_ff;
  dio_regs_pkg::group_state_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (i_wr) begin
      case (i_mode)
        dio_regs_pkg::MODE_PRESET: nxt_st.value = i_wdata;
        dio_regs_pkg::MODE_DIRECTION: nxt_st.dir = i_wdata;
        dio_regs_pkg::MODE_OPERATION: begin
          nxt_st.value = (st_ff.value & ~st_ff.dir) | (i_wdata & st_ff.dir);
        end
        default: nxt_st = st_ff;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_ff.value <= dio_regs_pkg::GROUP_RESET;
      st_ff.dir <= dio_regs_pkg::GROUP_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // input bits are left undriven; the stored value only reaches pins set as outputs
  assign o_pin_out = st_ff.value;
  assign o_pin_oe = st_ff.dir;

  always_comb begin
    case (i_mode)
      dio_regs_pkg::MODE_PRESET: o_rdata = st_ff.value;
      dio_regs_pkg::MODE_DIRECTION: o_rdata = st_ff.dir;
      dio_regs_pkg::MODE_OPERATION: o_rdata = (i_pins & ~st_ff.dir) | (st_ff.value & st_ff.dir);
      default: o_rdata = i_pins;
    endcase
  end

  property p_preset_write;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_wr && i_mode == dio_regs_pkg::MODE_PRESET |=> st_ff.value == $past(i_wdata);
  endproperty
  a_preset_write: assert property (p_preset_write) else $error("preset write not stored");

  property p_dir_write;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_wr && i_mode == dio_regs_pkg::MODE_DIRECTION |=> o_pin_oe == $past(i_wdata);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write not applied");

  property p_oper_inputs_kept;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_wr && i_mode == dio_regs_pkg::MODE_OPERATION |=>
        ((st_ff.value ^ $past(st_ff.value)) & ~$past(st_ff.dir)) == '0;
  endproperty
  a_oper_inputs_kept: assert property (p_oper_inputs_kept) else $error("operation write touched input bit");

  property p_undef_frozen;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_wr && i_mode == dio_regs_pkg::MODE_UNDEF |=> $stable(st_ff);
  endproperty
  a_undef_frozen: assert property (p_undef_frozen) else $error("write in undefined mode changed state");

  property p_preset_read;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_wr && i_mode == dio_regs_pkg::MODE_PRESET ##1 i_mode == dio_regs_pkg::MODE_PRESET && !i_wr
        |-> o_rdata == $past(i_wdata);
  endproperty
  a_preset_read: assert property (p_preset_read) else $error("preset readback wrong");

  c_dir_then_oper: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    i_wr && i_mode == dio_regs_pkg::MODE_DIRECTION ##[1:20] i_wr && i_mode == dio_regs_pkg::MODE_OPERATION);
endmodule

// *** hw/port_mode_and_power_outputs.sv ***
// port-two mode selector, port-two data groups and four high-current outputs with isolated inputs
`timescale 1ns/1ns
module port_mode_and_power_outputs #(
  parameter int GROUP_WIDTH = 8,
  parameter int POWER_COUNT = 4
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [POWER_COUNT-1:0] i_iso_in,
  input wire logic i_irq_route_en,
  input wire logic [3*GROUP_WIDTH-1:0] i_port2_pins,
  output logic [7:0] o_rdata,
  output logic [POWER_COUNT-1:0] o_power_drive,
  output logic o_irq,
  output logic [3*GROUP_WIDTH-1:0] o_port2_out,
  output logic [3*GROUP_WIDTH-1:0] o_port2_oe
);
  dio_regs_pkg::bus_req_type req;
  dio_regs_pkg::top_state_type st_ff;
  dio_regs_pkg::top_state_type nxt_st;
  logic [2:0] grp_wr;
  logic [3*GROUP_WIDTH-1:0] grp_rdata;
  logic [7:0] power_view;

  assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  // groups a, b, c sit at consecutive offsets from the first group
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_group
      assign grp_wr[g] = req.wr && (req.addr == dio_regs_pkg::OFS_GROUP_A + 4'(g));
      port2_group #(.WIDTH(GROUP_WIDTH)) u_group (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_wr(grp_wr[g]),
        .i_mode(st_ff.mode),
        .i_wdata(req.wdata[GROUP_WIDTH-1:0]),
        .i_pins(i_port2_pins[g*GROUP_WIDTH +: GROUP_WIDTH]),
        .o_pin_out(o_port2_out[g*GROUP_WIDTH +: GROUP_WIDTH]),
        .o_pin_oe(o_port2_oe[g*GROUP_WIDTH +: GROUP_WIDTH]),
        .o_rdata(grp_rdata[g*GROUP_WIDTH +: GROUP_WIDTH])
      );
    end
  endgenerate

  // status reads inverted because the drivers are low-side switches; inputs pass as live levels
  assign power_view = {i_iso_in, ~st_ff.power};

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = st_ff.rdata;
    if (req.wr) begin
      if (req.addr == dio_regs_pkg::OFS_MODE_CTRL) begin
        nxt_st.mode = req.wdata[1:0];
      end else if (req.addr == dio_regs_pkg::OFS_POWER_0) begin
        nxt_st.power[0] = req.wdata[0];
      end else if (req.addr == dio_regs_pkg::OFS_POWER_1) begin
        nxt_st.power[1] = req.wdata[1];
      end else if (req.addr == dio_regs_pkg::OFS_POWER_2) begin
        nxt_st.power[2] = req.wdata[2];
      end else if (req.addr == dio_regs_pkg::OFS_POWER_3) begin
        nxt_st.power[3] = req.wdata[3];
      end
    end
    if (req.rd) begin
      if (req.addr == dio_regs_pkg::OFS_GROUP_A) begin
        nxt_st.rdata = grp_rdata[0 +: 8];
      end else if (req.addr == dio_regs_pkg::OFS_GROUP_B) begin
        nxt_st.rdata = grp_rdata[8 +: 8];
      end else if (req.addr == dio_regs_pkg::OFS_GROUP_C) begin
        nxt_st.rdata = grp_rdata[16 +: 8];
      end else if (req.addr == dio_regs_pkg::OFS_MODE_CTRL) begin
        nxt_st.rdata = {6'h00, st_ff.mode};
      end else if (req.addr >= dio_regs_pkg::OFS_POWER_0 && req.addr <= dio_regs_pkg::OFS_POWER_3) begin
        nxt_st.rdata = power_view;
      end else begin
        nxt_st.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_ff.mode <= dio_regs_pkg::MODE_RESET;
      st_ff.power <= dio_regs_pkg::POWER_RESET;
      st_ff.rdata <= dio_regs_pkg::RDATA_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata = st_ff.rdata;
  assign o_power_drive = st_ff.power;
  assign o_irq = i_irq_route_en & i_iso_in[0];

  property p_mode_write;
    @(posedge i_clock) disable iff (!i_rst_n)
      req.wr && req.addr == dio_regs_pkg::OFS_MODE_CTRL |=> st_ff.mode == $past(req.wdata[1:0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode field not written");

  property p_power_read;
    @(posedge i_clock) disable iff (!i_rst_n)
      req.rd && !req.wr && req.addr >= dio_regs_pkg::OFS_POWER_0 && req.addr <= dio_regs_pkg::OFS_POWER_3
        |=> o_rdata[7:dio_regs_pkg::IN_LSB] == $past(i_iso_in)
          && o_rdata[dio_regs_pkg::IN_LSB-1:0] == ~o_power_drive;
  endproperty
  a_power_read: assert property (p_power_read) else $error("power register readback wrong");

  property p_power0;
    @(posedge i_clock) disable iff (!i_rst_n)
      req.wr && req.addr == dio_regs_pkg::OFS_POWER_0 |=> o_power_drive[0] == $past(req.wdata[0]);
  endproperty
  a_power0: assert property (p_power0) else $error("output 0 not set");

  property p_power1;
    @(posedge i_clock) disable iff (!i_rst_n)
      req.wr && req.addr == dio_regs_pkg::OFS_POWER_1 |=> o_power_drive[1] == $past(req.wdata[1]);
  endproperty
  a_power1: assert property (p_power1) else $error("output 1 not set");

  property p_power2;
    @(posedge i_clock) disable iff (!i_rst_n)
      req.wr && req.addr == dio_regs_pkg::OFS_POWER_2 |=> o_power_drive[2] == $past(req.wdata[2]);
  endproperty
  a_power2: assert property (p_power2) else $error("output 2 not set");

  property p_power3;
    @(posedge i_clock) disable iff (!i_rst_n)
      req.wr && req.addr == dio_regs_pkg::OFS_POWER_3 |=> o_power_drive[3] == $past(req.wdata[3]);
  endproperty
  a_power3: assert property (p_power3) else $error("output 3 not set");

  property p_power_isolated;
    @(posedge i_clock) disable iff (!i_rst_n)
      req.wr && req.addr == dio_regs_pkg::OFS_POWER_0 |=> o_power_drive[3:1] == $past(o_power_drive[3:1]);
  endproperty
  a_power_isolated: assert property (p_power_isolated) else $error("write disturbed other outputs");

  property p_irq_level;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_irq == (i_irq_route_en && i_iso_in[0]);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt does not follow input 0");

  property p_power1_isolated;
    @(posedge i_clock) disable iff (!i_rst_n)
      req.wr && req.addr == dio_regs_pkg::OFS_POWER_1
        |=> {o_power_drive[3:2], o_power_drive[0]} == $past({o_power_drive[3:2], o_power_drive[0]});
  endproperty
  a_power1_isolated: assert property (p_power1_isolated) else $error("write disturbed other outputs");

  property p_power2_isolated;
    @(posedge i_clock) disable iff (!i_rst_n)
      req.wr && req.addr == dio_regs_pkg::OFS_POWER_2
        |=> {o_power_drive[3], o_power_drive[1:0]} == $past({o_power_drive[3], o_power_drive[1:0]});
  endproperty
  a_power2_isolated: assert property (p_power2_isolated) else $error("write disturbed other outputs");

  property p_power3_isolated;
    @(posedge i_clock) disable iff (!i_rst_n)
      req.wr && req.addr == dio_regs_pkg::OFS_POWER_3
        |=> o_power_drive[2:0] == $past(o_power_drive[2:0]);
  endproperty
  a_power3_isolated: assert property (p_power3_isolated) else $error("write disturbed other outputs");

  // no disable here: the reset itself is what is checked
  property p_reset_state;
    @(posedge i_clock)
      !i_rst_n |=> st_ff.mode == dio_regs_pkg::MODE_RESET && o_power_drive == dio_regs_pkg::POWER_RESET;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_mode_read;
    @(posedge i_clock) disable iff (!i_rst_n)
      req.rd && req.addr == dio_regs_pkg::OFS_MODE_CTRL
        |=> o_rdata[7:2] == 6'h00 && o_rdata[1:0] == $past(st_ff.mode);
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");

  property p_dir_read;
    @(posedge i_clock) disable iff (!i_rst_n)
      req.rd && req.addr == dio_regs_pkg::OFS_GROUP_A && st_ff.mode == dio_regs_pkg::MODE_DIRECTION
        |=> o_rdata == $past(o_port2_oe[7:0]);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction readback wrong");

  // the host may poll late, so read data must stand until the next read
  property p_rdata_held;
    @(posedge i_clock) disable iff (!i_rst_n)
      !req.rd |=> $stable(o_rdata);
  endproperty
  a_rdata_held: assert property (p_rdata_held) else $error("read data moved without a read");

  property p_power_keeps_mode;
    @(posedge i_clock) disable iff (!i_rst_n)
      req.wr && req.addr >= dio_regs_pkg::OFS_POWER_0 && req.addr <= dio_regs_pkg::OFS_POWER_3
        |=> $stable(st_ff.mode);
  endproperty
  a_power_keeps_mode: assert property (p_power_keeps_mode) else $error("power write changed mode");

  property p_mode_keeps_power;
    @(posedge i_clock) disable iff (!i_rst_n)
      req.wr && req.addr == dio_regs_pkg::OFS_MODE_CTRL |=> $stable(o_power_drive);
  endproperty
  a_mode_keeps_power: assert property (p_mode_keeps_power) else $error("mode write changed outputs");

  c_mode_preset: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    st_ff.mode == dio_regs_pkg::MODE_PRESET ##1 grp_wr[0]);
  c_all_power_on: cover property (@(posedge i_clock) disable iff (!i_rst_n) o_power_drive == 4'hf);
  c_irq_held: cover property (@(posedge i_clock) disable iff (!i_rst_n) o_irq [*3]);
  c_status_read: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    req.rd && req.addr == dio_regs_pkg::OFS_POWER_3 ##1 o_rdata[3:0] != 4'hf);
endmodule

// *** verif/pin_side_model.sv ***
// far side of the port-two pins: resolves each pin from the card's drive and the outside world
`timescale 1ns/1ns
module pin_side_model (
  input wire logic [23:0] i_oe,
  input wire logic [23:0] i_out,
  input wire logic [23:0] i_ext,
  output logic [23:0] o_pins
);
  // input bits see the outside pattern, never the stale driven value
  assign o_pins = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

// *** verif/port_mode_and_power_outputs_tb.sv ***
// self-checking bench for the port-two mode and power-output registers
`timescale 1ns/1ns
module port_mode_and_power_outputs_tb;
  logic i_clock, i_rst_n, i_wr, i_rd, i_irq_route_en, o_irq;
  logic [3:0] i_addr, i_iso_in, o_power_drive;
  logic [7:0] i_wdata, o_rdata;
  logic [23:0] pins, ext, o_port2_out, o_port2_oe;
  int n_fail = 0;
  int checked = 0;

  port_mode_and_power_outputs dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_iso_in(i_iso_in), .i_irq_route_en(i_irq_route_en),
    .i_port2_pins(pins), .o_rdata(o_rdata), .o_power_drive(o_power_drive), .o_irq(o_irq),
    .o_port2_out(o_port2_out), .o_port2_oe(o_port2_oe));
  pin_side_model pin_env (.i_oe(o_port2_oe), .i_out(o_port2_out), .i_ext(ext), .o_pins(pins));

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  task automatic end_of_test();
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
    #1;
  endtask

  // read data is registered on the edge that takes the request, so it is sampled just past that edge
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp, what);
  endtask

  task automatic t_reset();
    rd(dio_regs_pkg::OFS_MODE_CTRL, 8'h03, "mode after reset");
    chk({4'h0, o_power_drive}, 8'h00, "drive after reset");
    rd(dio_regs_pkg::OFS_POWER_2, {i_iso_in, 4'hf}, "status after reset");
  endtask

  // every register write carries ones in foreign bits to show only the owned output moves
  task automatic t_power();
    logic [3:0] exp;
    exp = 4'h0;
    for (int i = 0; i < 4; i++) begin
      wr(dio_regs_pkg::OFS_POWER_0 + 4'(i), 8'hff);
      exp[i] = 1'b1;
      chk({4'h0, o_power_drive}, {4'h0, exp}, "drive set");
      @(posedge i_clock);
      i_iso_in <= 4'(i * 3 + 1);
      rd(dio_regs_pkg::OFS_POWER_0 + 4'(3 - i), {4'(i * 3 + 1), ~exp}, "status");
    end
    wr(dio_regs_pkg::OFS_POWER_1, 8'hfd);
    exp = 4'hd;
    chk({4'h0, o_power_drive}, {4'h0, exp}, "drive clear");
    for (int i = 0; i < 4; i++) begin
      wr(dio_regs_pkg::OFS_POWER_0 + 4'(i), ~(8'h01 << i));
      exp[i] = 1'b0;
      chk({4'h0, o_power_drive}, {4'h0, exp}, "drive off");
    end
  endtask

  task automatic t_mode();
    for (int m = 1; m < 4; m++) begin
      wr(dio_regs_pkg::OFS_MODE_CTRL, 8'(m));
      rd(dio_regs_pkg::OFS_MODE_CTRL, 8'(m), "mode readback");
    end
  endtask

  task automatic t_port2();
    logic [3:0] a;
    for (int g = 0; g < 3; g++) begin
      a = dio_regs_pkg::OFS_GROUP_A + 4'(g);
      wr(dio_regs_pkg::OFS_MODE_CTRL, 8'h02);
      wr(a, 8'hf0);
      chk(o_port2_oe[8*g +: 8], 8'hf0, "direction");
      rd(a, 8'hf0, "direction read");
      wr(dio_regs_pkg::OFS_MODE_CTRL, 8'h01);
      wr(a, 8'h5a);
      chk(o_port2_out[8*g +: 8], 8'h5a, "preset");
      rd(a, 8'h5a, "preset read");
      wr(dio_regs_pkg::OFS_MODE_CTRL, 8'h03);
      rd(a, 8'h53, "operation read");
      wr(a, 8'hff);
      chk(o_port2_out[8*g +: 8], 8'hfa, "operation write");
      wr(dio_regs_pkg::OFS_MODE_CTRL, 8'h00);
      wr(a, 8'h00);
      chk(o_port2_out[8*g +: 8], 8'hfa, "undef value");
      chk(o_port2_oe[8*g +: 8], 8'hf0, "undef dir");
      rd(a, 8'hf3, "undef read");
    end
  endtask

  // a second reset in mid-run must clear a lit output and every direction, and return the mode to operation (3)
  task automatic t_rerun_reset();
    wr(dio_regs_pkg::OFS_POWER_2, 8'h04);
    chk({4'h0, o_power_drive}, 8'h04, "drive before reset2");
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    #1;
    chk({4'h0, o_power_drive}, 8'h00, "drive after reset2");
    chk(o_port2_oe[7:0] | o_port2_oe[15:8] | o_port2_oe[23:16], 8'h00, "dirs after reset2");
    rd(dio_regs_pkg::OFS_MODE_CTRL, 8'h03, "mode after reset2");
  endtask

  task automatic t_irq();
    @(posedge i_clock);
    i_iso_in <= 4'h1;
    i_irq_route_en <= 1'b0;
    #1;
    chk({7'h0, o_irq}, 8'h00, "irq unrouted");
    @(posedge i_clock);
    i_irq_route_en <= 1'b1;
    repeat (4) @(posedge i_clock);
    #1;
    chk({7'h0, o_irq}, 8'h01, "irq level");
    @(posedge i_clock);
    i_iso_in <= 4'h0;
    #1;
    chk({7'h0, o_irq}, 8'h00, "irq drop");
  endtask

  initial begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_iso_in = 4'ha;
    i_irq_route_en = 1'b0;
    ext = 24'h333333;
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_reset();
    t_power();
    t_mode();
    t_port2();
    t_rerun_reset();
    t_irq();
    end_of_test();
  end

  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
endmodule
